// ===== uir_regs.svh
// Register map, field positions, reset values and timing counts
// Assumes a word-addressed Avalon-MM slave port of three address bits
`ifndef UIR_REGS_SVH
`define UIR_REGS_SVH
// Word indices; byte address is four times the index
`define UIR_MODE_IDX 3'h0
`define UIR_STA_IDX 3'h1
`define UIR_TXD_IDX 3'h2
`define UIR_RXD_IDX 3'h3
`define UIR_BRG_IDX 3'h4
// Mode register fields
`define UIR_M_ON 15
`define UIR_M_INFRARED_ENABLE_BIT 12
`define UIR_M_UEN_HI 9
`define UIR_M_UEN_LO 8
`define UIR_M_LPBK 6
`define UIR_M_HIGH_SPEED_BAUD_SELECT 3
`define UIR_M_PD_HI 2
`define UIR_M_PD_LO 1
`define UIR_M_STSEL 0
`define UIR_MODE_RST 16'h0000
// Status and control register fields
`define UIR_S_TXIS_HI 15
`define UIR_S_TXIS_LO 14
`define UIR_S_RXIS_HI 13
`define UIR_S_RXIS_LO 12
`define UIR_S_BRK 11
`define UIR_S_TXEN 10
`define UIR_S_ADDEN 5
`define UIR_S_OVERRUN_FLAG 1
`define UIR_STA_RST 16'h0000
`define UIR_BRG_RST 16'h0000
// Parity and data selections
`define UIR_PD_8N 2'h0
`define UIR_PD_8E 2'h1
`define UIR_PD_8O 2'h2
`define UIR_PD_9N 2'h3
// Pin enable field codes
`define UIR_UEN_RTS 2'h1
`define UIR_UEN_FLOW 2'h2
`define UIR_UEN_BCLK 2'h3
// Interrupt select codes
`define UIR_TXI_LOAD 2'h0
`define UIR_TXI_DONE 2'h1
`define UIR_TXI_EMPTY 2'h2
`define UIR_RXI_FILL3 2'h2
`define UIR_RXI_FULL 2'h3
// Sub-bit tick counts, minus one
`define UIR_TICKS_STD 4'hF
`define UIR_TICKS_HS 4'h3
`define UIR_HALF_STD 4'h7
`define UIR_HALF_HS 4'h1
// Infrared pulse width in ticks, break length in bit times minus one
`define UIR_IR_PULSE 4'h3
`define UIR_BRK_BITS 4'hC
`define UIR_TXI_DELAY 2'h2
`endif

// ===== uir_pkg.sv
// Types shared by the serial transceiver
// Assumes the register header is included where numbers are needed
package uir_pkg;
  typedef enum logic [5:0] {
    UIR_TX_IDLE = 6'h01,
    UIR_TX_START = 6'h02,
    UIR_TX_DATA = 6'h04,
    UIR_TX_PAR = 6'h08,
    UIR_TX_STOP = 6'h10,
    UIR_TX_BRK = 6'h20
  } uir_tx_state_type;
  typedef enum logic [4:0] {
    UIR_RX_IDLE = 5'h01,
    UIR_RX_START = 5'h02,
    UIR_RX_DATA = 5'h04,
    UIR_RX_PAR = 5'h08,
    UIR_RX_STOP = 5'h10
  } uir_rx_state_type;
endpackage

// ===== uir_uart.sv
// Serial transceiver with infrared codec, 4-deep FIFOs, Avalon-MM slave
// Assumes one clock; serial pins come from outside and are synchronised
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "uir_regs.svh"
module uir_uart #(
  parameter int DEPTH_LOG2 = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial pins
  input wire logic serial_rx_pin_i,
  input wire logic clear_to_send_in_n_i,
  output logic serial_tx_pin_o,
  output logic request_to_send_out_n_o,
  // Event pulses
  output logic tx_int_o,
  output logic rx_int_o
);
  import uir_pkg::*;
  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam int CW = DEPTH_LOG2 + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus handshake
  logic [15:0] mode, sta_ctl, brg;
  logic wait_q, overrun_flag, txen_d1;
  wire req = avs_read_i | avs_write_i;
  wire acc = req & ~wait_q;
  wire wr_acc = acc & avs_write_i;
  wire rd_acc = acc & avs_read_i;
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction
  // Decoded fields
  wire on = mode[`UIR_M_ON];
  wire high_speed_baud_select = mode[`UIR_M_HIGH_SPEED_BAUD_SELECT];
  wire ir_on = mode[`UIR_M_INFRARED_ENABLE_BIT] & ~high_speed_baud_select;
  wire lpbk = mode[`UIR_M_LPBK];
  wire [1:0] pdsel = mode[`UIR_M_PD_HI:`UIR_M_PD_LO];
  wire [1:0] uen = mode[`UIR_M_UEN_HI:`UIR_M_UEN_LO];
  wire nine = (pdsel == `UIR_PD_9N);
  wire txen = sta_ctl[`UIR_S_TXEN];
  wire txbrk = sta_ctl[`UIR_S_BRK];
  wire [1:0] txis = sta_ctl[`UIR_S_TXIS_HI:`UIR_S_TXIS_LO];
  wire [1:0] rxis = sta_ctl[`UIR_S_RXIS_HI:`UIR_S_RXIS_LO];
  wire txen_rise = wr_acc & hit(avs_address_i, `UIR_STA_IDX) & ~txen
                   & avs_writedata_i[`UIR_S_TXEN];
  wire [3:0] tlast = high_speed_baud_select ? `UIR_TICKS_HS : `UIR_TICKS_STD;
  wire [3:0] thalf = high_speed_baud_select ? `UIR_HALF_HS : `UIR_HALF_STD;
  logic brk_done, ovf;

  // Wait state: one cycle of waitrequest per access
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Control registers written by software
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode <= `UIR_MODE_RST;
      sta_ctl <= `UIR_STA_RST;
      brg <= `UIR_BRG_RST;
    end else begin
      if (wr_acc && hit(avs_address_i, `UIR_MODE_IDX)) begin
        mode <= avs_writedata_i[15:0];
      end
      if (wr_acc && hit(avs_address_i, `UIR_BRG_IDX)) begin
        brg <= avs_writedata_i[15:0];
      end
      if (wr_acc && hit(avs_address_i, `UIR_STA_IDX)) begin
        sta_ctl <= avs_writedata_i[15:0];
      end else if (brk_done) begin
        sta_ctl[`UIR_S_BRK] <= 1'b0;
      end
    end
  end

  // Overrun flag: set wins over software clear
  wire overrun_flag_clr = wr_acc & hit(avs_address_i, `UIR_STA_IDX) & ~avs_writedata_i[`UIR_S_OVERRUN_FLAG];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overrun_flag <= 1'b0;
    end else if (ovf) begin
      overrun_flag <= 1'b1;
    end else if (overrun_flag_clr) begin
      overrun_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator, cleared on enable or transmit enable
  logic [15:0] bcnt;
  logic bclk;
  wire tick = (bcnt == brg);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bcnt <= 16'h0000;
      bclk <= 1'b0;
    end else begin
      bcnt <= (!on || txen_rise || tick) ? 16'h0000 : bcnt + 16'h0001;
      bclk <= on && (bcnt <= (brg >> 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  logic [8:0] tx_mem [DEPTH];
  logic [DEPTH_LOG2-1:0] tx_wp, tx_rp;
  logic [CW-1:0] tx_cnt;
  logic tx_pop;
  wire tx_full = (tx_cnt == CW'(DEPTH));
  wire tx_empty = (tx_cnt == '0);
  wire txd_wr = wr_acc & hit(avs_address_i, `UIR_TXD_IDX) & avs_byteenable_i[0];
  wire tx_push = txd_wr & ~tx_full;
  // Ninth bit only taken from a write that enables byte lane 1
  wire [8:0] tx_wdata = {nine & avs_byteenable_i[1] & avs_writedata_i[8],
                         avs_writedata_i[7:0]};
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + DEPTH_LOG2'(tx_push);
      tx_rp <= tx_rp + DEPTH_LOG2'(tx_pop);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
    end
  end
  always_ff @(posedge clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= tx_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  uir_tx_state_type tx_st;
  logic [8:0] tx_sh;
  logic [3:0] tx_sub, tx_bit;
  logic tx_par, tx_stop2, tx_done;
  logic cts_s1, cts_s2;
  wire cts_ok = (uen != `UIR_UEN_FLOW) | ~cts_s2;
  wire tx_bend = tick & (tx_sub == tlast);
  wire [3:0] tx_nbits = nine ? 4'h9 : 4'h8;
  wire [8:0] tx_head = tx_mem[tx_rp];
  wire head_par = ^tx_head[7:0] ^ (pdsel == `UIR_PD_8O);
  wire par_on = (pdsel == `UIR_PD_8E) | (pdsel == `UIR_PD_8O);
  assign tx_pop = (tx_st == UIR_TX_IDLE) & on & txen & ~tx_empty & cts_ok;
  assign brk_done = (tx_st == UIR_TX_BRK) & tx_bend & (tx_bit == `UIR_BRK_BITS);
  // Line level for the current state
  logic tx_line;
  always_comb begin
    case (tx_st)
      UIR_TX_START: tx_line = 1'b0;
      UIR_TX_DATA: tx_line = tx_sh[0];
      UIR_TX_PAR: tx_line = tx_par;
      UIR_TX_BRK: tx_line = 1'b0;
      default: tx_line = 1'b1;
    endcase
  end

  // Clear-to-send synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end else begin
      cts_s1 <= clear_to_send_in_n_i;
      cts_s2 <= cts_s1;
    end
  end

  // Transmit state machine
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st <= UIR_TX_IDLE;
      tx_sh <= 9'h000;
      tx_sub <= 4'h0;
      tx_bit <= 4'h0;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_sub <= (tick && tx_st != UIR_TX_IDLE) ? ((tx_sub == tlast) ? 4'h0 : tx_sub + 4'h1)
                : tx_sub;
      case (tx_st)
        UIR_TX_IDLE: begin
          tx_sub <= 4'h0;
          tx_bit <= 4'h0;
          if (tx_pop) begin
            tx_sh <= tx_head;
            tx_par <= head_par;
            tx_st <= txbrk ? UIR_TX_BRK : UIR_TX_START;
          end
        end
        UIR_TX_START: begin
          if (tx_bend) begin
            tx_st <= UIR_TX_DATA;
          end
        end
        UIR_TX_DATA: begin
          if (tx_bend) begin
            tx_sh <= {1'b0, tx_sh[8:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == tx_nbits - 4'h1) begin
              tx_st <= par_on ? UIR_TX_PAR : UIR_TX_STOP;
            end
          end
        end
        UIR_TX_PAR: begin
          if (tx_bend) begin
            tx_st <= UIR_TX_STOP;
          end
        end
        UIR_TX_BRK: begin
          if (tx_bend) begin
            tx_bit <= tx_bit + 4'h1;
            if (brk_done) begin
              tx_st <= UIR_TX_STOP;
            end
          end
        end
        UIR_TX_STOP: begin
          if (tx_bend) begin
            tx_stop2 <= ~tx_stop2 & mode[`UIR_M_STSEL];
            if (tx_stop2 || !mode[`UIR_M_STSEL]) begin
              tx_st <= UIR_TX_IDLE;
              tx_done <= 1'b1;
            end
          end
        end
        default: tx_st <= UIR_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive front end: synchroniser, infrared decoder, loopback
  logic rx_s1, rx_s2, tx_q;
  logic [3:0] ir_hold;
  wire ir_bit = (ir_hold == 4'h0);
  wire rx_in = lpbk ? tx_q : (ir_on ? ir_bit : rx_s2);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      tx_q <= 1'b1;
      ir_hold <= 4'h0;
    end else begin
      rx_s1 <= serial_rx_pin_i;
      rx_s2 <= rx_s1;
      tx_q <= tx_line;
      // A low pulse from the detector holds a zero for one bit time
      if (!rx_s2) begin
        ir_hold <= `UIR_TICKS_STD;
      end else if (tick && ir_hold != 4'h0) begin
        ir_hold <= ir_hold - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO: data, parity error, framing error
  logic [10:0] rx_mem [DEPTH];
  logic [DEPTH_LOG2-1:0] rx_wp, rx_rp;
  logic [CW-1:0] rx_cnt;
  logic rx_push;
  logic [10:0] rx_wdata;
  wire rx_full = (rx_cnt == CW'(DEPTH));
  wire rx_empty = (rx_cnt == '0);
  wire rx_pop = rd_acc & hit(avs_address_i, `UIR_RXD_IDX) & ~rx_empty;
  wire [10:0] rx_head = rx_mem[rx_rp];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp <= rx_wp + DEPTH_LOG2'(rx_push);
      rx_rp <= rx_rp + DEPTH_LOG2'(rx_pop);
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start check at half bit, then sample mid-bit
  uir_rx_state_type rx_st;
  logic [8:0] rx_sh;
  logic [3:0] rx_sub, rx_bit;
  logic rx_parity_error_flag, rx_done, rx_lowstop;
  wire rx_samp = tick & (rx_sub == tlast);
  wire [8:0] rx_data = nine ? rx_sh : {1'b0, rx_sh[8:1]};
  wire rx_keep = ~(nine & sta_ctl[`UIR_S_ADDEN]) | rx_sh[8];
  assign rx_wdata = {rx_parity_error_flag, ~rx_in, rx_data};
  assign rx_push = rx_done & rx_keep & ~rx_full;
  assign ovf = rx_done & rx_keep & rx_full;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st <= UIR_RX_IDLE;
      rx_sh <= 9'h000;
      rx_sub <= 4'h0;
      rx_bit <= 4'h0;
      rx_parity_error_flag <= 1'b0;
      rx_lowstop <= 1'b0;
    end else begin
      rx_sub <= tick ? ((rx_sub == tlast) ? 4'h0 : rx_sub + 4'h1) : rx_sub;
      case (rx_st)
        UIR_RX_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 4'h0;
          rx_parity_error_flag <= 1'b0;
          // A low stop bit must see the line high before a new start
          rx_lowstop <= rx_lowstop & ~rx_in;
          if (on && !rx_in && !rx_lowstop) begin
            rx_st <= UIR_RX_START;
          end
        end
        UIR_RX_START: begin
          if (tick && rx_sub == thalf) begin
            rx_sub <= 4'h0;
            rx_st <= rx_in ? UIR_RX_IDLE : UIR_RX_DATA;
          end
        end
        UIR_RX_DATA: begin
          if (rx_samp) begin
            rx_sh <= {rx_in, rx_sh[8:1]};
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == tx_nbits - 4'h1) begin
              rx_st <= par_on ? UIR_RX_PAR : UIR_RX_STOP;
            end
          end
        end
        UIR_RX_PAR: begin
          if (rx_samp) begin
            rx_parity_error_flag <= rx_in ^ ^rx_sh[8:1] ^ (pdsel == `UIR_PD_8O);
            rx_st <= UIR_RX_STOP;
          end
        end
        UIR_RX_STOP: begin
          if (rx_samp) begin
            rx_lowstop <= ~rx_in;
            rx_st <= UIR_RX_IDLE;
          end
        end
        default: rx_st <= UIR_RX_IDLE;
      endcase
    end
  end
  assign rx_done = (rx_st == UIR_RX_STOP) & rx_samp;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses and transmit enable delay
  wire tx_ev = (txis == `UIR_TXI_LOAD) ? tx_pop :
               (txis == `UIR_TXI_DONE) ? (tx_done & tx_empty) :
               (txis == `UIR_TXI_EMPTY) ? (tx_pop & (tx_cnt == CW'(1))) : 1'b0;
  wire rx_ev = (rxis == `UIR_RXI_FULL) ? (rx_push & (rx_cnt == CW'(DEPTH - 1))) :
               (rxis == `UIR_RXI_FILL3) ? (rx_push & (rx_cnt == CW'(DEPTH - 2))) :
               rx_push;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txen_d1 <= 1'b0;
      tx_int_o <= 1'b0;
      rx_int_o <= 1'b0;
    end else begin
      txen_d1 <= txen_rise & on;
      tx_int_o <= txen_d1 | tx_ev;
      rx_int_o <= rx_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  wire ir_pulse = ~tx_line & (tx_sub < `UIR_IR_PULSE);
  wire rts_lvl = (uen == `UIR_UEN_BCLK) ? ~bclk : rx_full;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_tx_pin_o <= 1'b1;
      request_to_send_out_n_o <= 1'b1;
    end else begin
      serial_tx_pin_o <= ir_on ? (on & ir_pulse) : (~on | tx_line);
      // Field 11 drives the tick clock (16x at standard speed, 4x at high speed), 01 and 10 ready while space remains
      request_to_send_out_n_o <= (uen == 2'h0) | ~on | rts_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, captured at the first edge of an access
  wire [15:0] sta_rd = {sta_ctl[15:10], tx_full, tx_empty & (tx_st == UIR_TX_IDLE),
                        2'h0, sta_ctl[`UIR_S_ADDEN], rx_st == UIR_RX_IDLE,
                        rx_head[10] & ~rx_empty, rx_head[9] & ~rx_empty, overrun_flag, ~rx_empty};
  wire [15:0] rd_data = hit(avs_address_i, `UIR_MODE_IDX) ? mode :
                        hit(avs_address_i, `UIR_STA_IDX) ? sta_rd :
                        hit(avs_address_i, `UIR_RXD_IDX) ? {7'h00, rx_head[8:0]} :
                        hit(avs_address_i, `UIR_BRG_IDX) ? brg : 16'h0000;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && wait_q) begin
      avs_readdata_o <= {16'h0000, rd_data};
    end
  end
  assign avs_waitrequest_o = wait_q;
endmodule

// ===== uir_uart_monitor.sv
// Port checks for the serial transceiver: bus timing and event pulses
// Assumes binding to every uir_uart instance
`timescale 1ns/1ps
`include "uir_regs.svh"
module uir_uart_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Bus
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Events
  input wire logic tx_int_o,
  input wire logic rx_int_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("access not answered after one wait cycle");
  a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle_high: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  // Read values
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i > 3'h4 |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_upper_half_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_txd_reads_zero: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i == `UIR_TXD_IDX |-> avs_readdata_o == 32'h0) else $error("tx data read not zero");
  // Event pulses
  a_txint_single: assert property (tx_int_o |=> !tx_int_o)
    else $error("tx event longer than one cycle");
  a_rxint_single: assert property (rx_int_o |=> !rx_int_o)
    else $error("rx event longer than one cycle");
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
  c_write_done: cover property (avs_write_i && !avs_waitrequest_o);
  c_tx_event: cover property (tx_int_o);
  c_rx_event: cover property (rx_int_o);
endmodule
bind uir_uart uir_uart_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .tx_int_o(tx_int_o), .rx_int_o(rx_int_o));

// ===== uir_term.sv
// Remote serial terminal: captures frames from the line, sends raw frames
// Assumes BITCLK clocks per bit, matching the divisor set by the bench
`timescale 1ns/1ps
module uir_term #(
  parameter int BITCLK = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int nbits = 9;
  logic [11:0] q[$];
  logic [11:0] cap;
  initial line_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // Capture bits at their centres after a low start, stops stay as ones
  always begin
    @(negedge line_i);
    repeat (BITCLK / 2) @(posedge clk_i);
    cap = 12'hFFF;
    for (int i = 0; i < nbits; i++) begin
      repeat (BITCLK) @(posedge clk_i);
      cap[i] = line_i;
    end
    q.push_back(cap);
    while (line_i !== 1'b1) @(posedge clk_i);
  end
  // Low start, n bits LSB first, then idle high for two bits
  task automatic send(input logic [11:0] f, input int n);
    line_o <= 1'b0;
    repeat (BITCLK) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (BITCLK) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (2 * BITCLK) @(posedge clk_i);
  endtask
endmodule

// ===== uart_with_infrared_codec_tb.sv
// Bench for the transceiver: register accesses and serial traffic
// Assumes divisor 1, so a bit lasts 32 clocks at standard speed
`timescale 1ns/1ps
`include "uir_regs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, e); end end
module uart_with_infrared_codec_tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_o, rx, tx, rts_n, txi, rxi, p;
  logic [31:0] r;
  logic cts_n = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int txi_n = 0;
  int rxi_n = 0;
  int n0, t;
  logic [15:0] md [4] = '{16'h8000, 16'h8003, 16'h8004, 16'h8006};
  logic [8:0] dt [4] = '{9'h0A5, 9'h05A, 9'h0C3, 9'h1A5};
  int nd [4] = '{8, 8, 8, 9};
  int par [4] = '{0, 1, 2, 0};
  int nb [4] = '{9, 11, 10, 10};
  uir_uart dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .serial_rx_pin_i(rx),
    .clear_to_send_in_n_i(cts_n), .serial_tx_pin_o(tx), .request_to_send_out_n_o(rts_n),
    .tx_int_o(txi), .rx_int_o(rxi));
  uir_term #(.BITCLK(32)) term (.clk_i(clk_i), .line_i(tx), .line_o(rx));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and event counters
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (txi === 1'b1) txi_n++;
    if (rxi === 1'b1) rxi_n++;
  end
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
    input logic [3:0] b);
    int n;
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wrt(input logic [2:0] a, input logic [31:0] d, input logic [3:0] b = 4'hF);
    bus(1'b1, a, d, b);
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    `CHK(r, e)
  endtask
  // Status read into r, upper half must read zero
  task automatic rdst;
    bus(1'b0, `UIR_STA_IDX, 32'h0, 4'hF);
    `CHK(r[31:16], 16'h0)
  endtask
  // Bounded wait on frames captured, rx events or tx events
  task automatic wait_ev(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? term.q.size() : sel == 1 ? rxi_n : txi_n) < lim && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      mismatches++;
      final_report();
    end
    repeat (40) @(posedge clk_i);
  endtask
  function automatic logic [11:0] frame(input logic [8:0] d, input int n, input int pm);
    logic [11:0] f;
    f = 12'hFFF;
    for (int i = 0; i < n; i++) f[i] = d[i];
    if (pm != 0) f[n] = ^d[7:0] ^ (pm == 2);
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdchk(`UIR_MODE_IDX, 32'h0);
    rdchk(`UIR_BRG_IDX, 32'h0);
    rdchk(3'h5, 32'h0);
    wrt(`UIR_BRG_IDX, 32'h1);
    rdchk(`UIR_BRG_IDX, 32'h1);
    wrt(`UIR_MODE_IDX, 32'h8000);
    wrt(`UIR_TXD_IDX, 32'h3C);
    n0 = txi_n;
    wrt(`UIR_STA_IDX, 32'h0400);
    repeat (4) @(posedge clk_i);
    `CHK(txi_n > n0, 1'b1)
    for (int i = 0; i < 8 && tx !== 1'b0; i++) @(posedge clk_i);
    `CHK(tx, 1'b0)
    wait_ev(0, 1);
    `CHK(term.q[0], frame(9'h3C, 8, 0))
    // Every character format and tx event select
    for (int k = 0; k < 4; k++) begin
      wrt(`UIR_MODE_IDX, {16'h0, md[k]});
      wrt(`UIR_STA_IDX, 32'h0400 | ((k % 3) << 14));
      term.q.delete();
      term.nbits = nb[k];
      n0 = txi_n;
      wrt(`UIR_TXD_IDX, {23'h0, dt[k]}, (k == 3) ? 4'h3 : 4'h1);
      wait_ev(0, 1);
      `CHK(term.q[0], frame(dt[k], nd[k], par[k]))
      `CHK(txi_n > n0, 1'b1)
    end
    // Parity error on head only, then framing error
    wrt(`UIR_MODE_IDX, 32'h8002);
    n0 = rxi_n;
    term.send(12'h10F, 9);
    term.send(12'h131, 9);
    `CHK(rxi_n - n0, 2)
    rdst();
    `CHK(r[3], 1'b1)
    rdchk(`UIR_RXD_IDX, 32'h0F);
    rdst();
    `CHK(r[3], 1'b0)
    rdchk(`UIR_RXD_IDX, 32'h31);
    wrt(`UIR_MODE_IDX, 32'h8000);
    term.send(12'h033, 9);
    rdst();
    `CHK(r[2], 1'b1)
    rdchk(`UIR_RXD_IDX, 32'h33);
    // Overrun: fifth character dropped, flag held until cleared
    for (int k = 0; k < 5; k++) term.send(12'(12'h040 + k), 8);
    rdst();
    `CHK(r[1], 1'b1)
    wrt(`UIR_STA_IDX, 32'h0400);
    rdst();
    `CHK(r[1], 1'b0)
    for (int k = 0; k < 4; k++) rdchk(`UIR_RXD_IDX, 32'h40 + k);
    // Address detect drops data characters
    wrt(`UIR_MODE_IDX, 32'h8006);
    wrt(`UIR_STA_IDX, 32'h0420);
    term.send(12'h011, 9);
    term.send(12'h122, 9);
    rdchk(`UIR_RXD_IDX, 32'h122);
    rdst();
    `CHK(r[0], 1'b0)
    // Loopback
    wrt(`UIR_MODE_IDX, 32'h8040);
    wrt(`UIR_STA_IDX, 32'h0400);
    n0 = rxi_n;
    wrt(`UIR_TXD_IDX, 32'h96);
    wait_ev(1, n0 + 1);
    rdchk(`UIR_RXD_IDX, 32'h96);
    // Flow control holds transmit while clear-to-send is high
    wrt(`UIR_MODE_IDX, 32'h8200);
    term.q.delete();
    term.nbits = 9;
    cts_n <= 1'b1;
    wrt(`UIR_TXD_IDX, 32'h69);
    repeat (40) @(posedge clk_i);
    `CHK(tx, 1'b1)
    cts_n <= 1'b0;
    wait_ev(0, 1);
    `CHK(term.q[0], frame(9'h69, 8, 0))
    // Handshake pin and baud clock output
    wrt(`UIR_MODE_IDX, 32'h8100);
    repeat (4) @(posedge clk_i);
    `CHK(rts_n, 1'b0)
    wrt(`UIR_MODE_IDX, 32'h8300);
    t = 0;
    p = rts_n;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      if (rts_n !== p) t++;
      p = rts_n;
    end
    `CHK(t > 2, 1'b1)
    // Break with dummy, then sync character
    wrt(`UIR_MODE_IDX, 32'h8000);
    wrt(`UIR_STA_IDX, 32'h0);
    term.q.delete();
    term.nbits = 9;
    wrt(`UIR_STA_IDX, 32'h0C00);
    repeat (2) @(posedge clk_i);
    `CHK(txi, 1'b1)
    wrt(`UIR_TXD_IDX, 32'hFF);
    wrt(`UIR_TXD_IDX, 32'h55);
    wait_ev(0, 2);
    `CHK(term.q[0], 12'hE00)
    `CHK(term.q[1], frame(9'h55, 8, 0))
    rdst();
    `CHK(r[11], 1'b0)
    // Infrared idle level, and its disable at high speed
    wrt(`UIR_MODE_IDX, 32'h9000);
    repeat (4) @(posedge clk_i);
    `CHK(tx, 1'b0)
    wrt(`UIR_MODE_IDX, 32'h9008);
    repeat (4) @(posedge clk_i);
    `CHK(tx, 1'b1)
    final_report();
  end
endmodule
